// *** rtl/tbs_pkg.sv ***
// Constants shared by the two-bit slice datapath.
// Assumes a single clock and a synchronous active-high reset.
package tbs_pkg;
   localparam int FUNC_W = 7;
   localparam int SEL_W = 4;
   localparam int GRP_W = 3;
   localparam int SEL_LSB = 0;
   localparam int GRP_LSB = 4;
   localparam int NUM_SCRATCH = 10;
   localparam logic [2:0] GRP_ADD_BOTH = 3'h0;
   localparam logic [2:0] GRP_ADDR_LOAD = 3'h1;
   localparam logic [2:0] GRP_DECR = 3'h2;
   localparam logic [2:0] GRP_ADD_ONE = 3'h3;
   // Register-select codes: 0 to 9 pick scratchpads, pairs pick aux/sum.
   localparam logic [3:0] SEL_AUX_A = 4'hc;
   localparam logic [3:0] SEL_SUM_A = 4'hd;
   localparam logic [3:0] SEL_AUX_B = 4'ha;
   localparam logic [3:0] SEL_SUM_B = 4'hb;
   localparam logic [3:0] SEL_AUX_C = 4'he;
   localparam logic [3:0] SEL_SUM_C = 4'hf;
   localparam logic [3:0] SEL_LAST_SCRATCH = 4'h9;
   localparam logic [1:0] RESET_WORD = 2'h0;
   typedef enum logic [1:0] {
      tbs_grp_one,
      tbs_grp_mem,
      tbs_grp_three,
      tbs_grp_none
   } tbs_rgrp_e;
endpackage

// *** rtl/tbs_slice.sv ***
// Two-bit processor slice datapath, function groups 0 to 3.
// Assumes microcode inputs are synchronous to clk; bus inputs come from
// outside and are synchronised here. Three-state enables are active low.
`timescale 1ns/100ps

module tbs_slice #(
   parameter int WIDTH = 2
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [tbs_pkg::FUNC_W-1:0] micro_func,
   input wire logic [WIDTH-1:0] mask_bus,
   input wire logic [WIDTH-1:0] mem_in,
   input wire logic [WIDTH-1:0] ext_in,
   input wire logic carry_input,
   input wire logic shift_in_high,
   output logic carry_output,
   output logic carry_output_oe_n,
   output logic right_shift_out,
   output logic right_shift_out_oe_n,
   output logic look_gen,
   output logic look_prop,
   output logic [WIDTH-1:0] addr_out,
   output logic addr_out_oe_n,
   output logic [WIDTH-1:0] sum_out,
   output logic [WIDTH-1:0] aux_out
);

   // ********************************************************
   // Input synchronisers and microcode decode
   // ********************************************************

   logic [WIDTH-1:0] mem_s1_q;
   logic [WIDTH-1:0] mem_s2_q;
   logic [WIDTH-1:0] ext_s1_q;
   logic [WIDTH-1:0] ext_s2_q;
   logic carry_s1_q;
   logic carry_s2_q;
   logic shin_s1_q;
   logic shin_s2_q;

   // Bus pins pass two flip-flops before any logic looks at them.
   always_ff @(posedge clk)
   begin
      mem_s1_q <= mem_in;
      mem_s2_q <= mem_s1_q;
      ext_s1_q <= ext_in;
      ext_s2_q <= ext_s1_q;
      carry_s1_q <= carry_input;
      carry_s2_q <= carry_s1_q;
      shin_s1_q <= shift_in_high;
      shin_s2_q <= shin_s1_q;
   end

   logic [tbs_pkg::GRP_W-1:0] grp;
   logic [tbs_pkg::SEL_W-1:0] sel;
   tbs_pkg::tbs_rgrp_e rgrp;
   logic sel_sum;

   // Split the microfunction into operation group and register select.
   assign grp = micro_func[tbs_pkg::GRP_LSB +: tbs_pkg::GRP_W];
   assign sel = micro_func[tbs_pkg::SEL_LSB +: tbs_pkg::SEL_W];

   // Map the register-select code onto one of the three register groups.
   always_comb
   begin
      rgrp = tbs_pkg::tbs_grp_none;
      sel_sum = 1'b0;
      case (sel)
         tbs_pkg::SEL_AUX_A, tbs_pkg::SEL_SUM_A:
         begin
            rgrp = tbs_pkg::tbs_grp_one;
            sel_sum = (sel == tbs_pkg::SEL_SUM_A);
         end
         tbs_pkg::SEL_AUX_B, tbs_pkg::SEL_SUM_B:
         begin
            rgrp = tbs_pkg::tbs_grp_mem;
            sel_sum = (sel == tbs_pkg::SEL_SUM_B);
         end
         tbs_pkg::SEL_AUX_C, tbs_pkg::SEL_SUM_C:
         begin
            rgrp = tbs_pkg::tbs_grp_three;
            sel_sum = (sel == tbs_pkg::SEL_SUM_C);
         end
         default:
         begin
            rgrp = (sel <= tbs_pkg::SEL_LAST_SCRATCH) ?
                   tbs_pkg::tbs_grp_one : tbs_pkg::tbs_grp_none;
            sel_sum = 1'b0;
         end
      endcase
   end

   // ********************************************************
   // Register file and operand selection
   // ********************************************************

   logic [WIDTH-1:0] scratch_q [tbs_pkg::NUM_SCRATCH];
   logic [WIDTH-1:0] sum_register_q;
   logic [WIDTH-1:0] aux_q;
   logic [WIDTH-1:0] address_hold_reg_q;
   logic [WIDTH-1:0] rn;
   logic [WIDTH-1:0] at;
   logic is_scratch;

   assign is_scratch = (sel <= tbs_pkg::SEL_LAST_SCRATCH);
   assign at = sel_sum ? sum_register_q : aux_q;

   // Group-one operand: scratchpad, aux or the sum register itself.
   always_comb
   begin
      if (is_scratch)
         rn = scratch_q[sel];
      else
         rn = at;
   end

   // ********************************************************
   // Arithmetic unit
   // ********************************************************

   logic [WIDTH-1:0] op_a;
   logic [WIDTH-1:0] op_b;
   logic [WIDTH-1:0] res;
   logic [WIDTH:0] full_sum;
   logic wr_dest;
   logic wr_sum_too;
   logic wr_addr;
   logic [WIDTH-1:0] addr_d;
   logic is_shift;
   logic [WIDTH-1:0] sum_and_k;
   logic [WIDTH-1:0] ones;

   assign sum_and_k = sum_register_q & mask_bus;
   assign ones = '1;

   // Choose the two adder operands and the destinations per group.
   always_comb
   begin
      op_a = '0;
      op_b = '0;
      wr_dest = 1'b0;
      wr_sum_too = 1'b0;
      wr_addr = 1'b0;
      addr_d = address_hold_reg_q;
      is_shift = 1'b0;
      case (grp)
         tbs_pkg::GRP_ADD_BOTH:
         begin
            wr_dest = (rgrp != tbs_pkg::tbs_grp_none);
            case (rgrp)
               tbs_pkg::tbs_grp_one:
               begin
                  // Target equal to sum register adds the masked sum register to itself.
                  op_a = rn;
                  op_b = sum_and_k;
                  wr_sum_too = 1'b1;
               end
               tbs_pkg::tbs_grp_mem:
               begin
                  op_a = mem_s2_q;
                  op_b = sum_and_k;
               end
               default:
               begin
                  op_a = at;
                  is_shift = 1'b1;
               end
            endcase
         end
         tbs_pkg::GRP_ADDR_LOAD:
         begin
            wr_dest = (rgrp != tbs_pkg::tbs_grp_none);
            case (rgrp)
               tbs_pkg::tbs_grp_one:
               begin
                  op_a = rn;
                  op_b = mask_bus;
                  wr_addr = 1'b1;
                  addr_d = rn | mask_bus;
               end
               tbs_pkg::tbs_grp_mem:
               begin
                  op_a = mem_s2_q;
                  op_b = mask_bus;
                  wr_addr = 1'b1;
                  addr_d = mem_s2_q | mask_bus;
               end
               default:
               begin
                  op_a = ~at | mask_bus;
                  op_b = at & mask_bus;
               end
            endcase
         end
         tbs_pkg::GRP_DECR:
         begin
            wr_dest = (rgrp != tbs_pkg::tbs_grp_none);
            op_b = ones;
            if (rgrp == tbs_pkg::tbs_grp_three)
               op_a = ext_s2_q & mask_bus;
            else
               op_a = sum_and_k;
         end
         tbs_pkg::GRP_ADD_ONE:
         begin
            wr_dest = (rgrp != tbs_pkg::tbs_grp_none);
            case (rgrp)
               tbs_pkg::tbs_grp_one:
               begin
                  op_a = rn;
                  op_b = sum_and_k;
               end
               tbs_pkg::tbs_grp_mem:
               begin
                  op_a = mem_s2_q;
                  op_b = sum_and_k;
               end
               default:
               begin
                  op_a = at;
                  op_b = ext_s2_q & mask_bus;
               end
            endcase
         end
         default:
         begin
            wr_dest = 1'b0;
         end
      endcase
   end

   // Adder result; shift replaces it in the shift-right case.
   assign full_sum = {1'b0, op_a} + {1'b0, op_b} + {{WIDTH{1'b0}}, carry_s2_q};
   assign res = is_shift ? {shin_s2_q, at[WIDTH-1:1]} : full_sum[WIDTH-1:0];

   // ********************************************************
   // State update on the rising edge
   // ********************************************************

   // Scratchpad writes for codes 0 to 9.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < tbs_pkg::NUM_SCRATCH; i++)
            scratch_q[i] <= tbs_pkg::RESET_WORD;
      end
      else if (wr_dest && is_scratch)
         scratch_q[sel] <= res;
   end

   // Sum register: written as target or as the group-0 copy.
   always_ff @(posedge clk)
   begin
      if (reset)
         sum_register_q <= tbs_pkg::RESET_WORD;
      else if (wr_dest && (wr_sum_too || (!is_scratch && sel_sum)))
         sum_register_q <= res;
   end

   // Auxiliary register write.
   always_ff @(posedge clk)
   begin
      if (reset)
         aux_q <= tbs_pkg::RESET_WORD;
      else if (wr_dest && !is_scratch && !sel_sum)
         aux_q <= res;
   end

   // Address register, loaded only by group 1 register transfers.
   always_ff @(posedge clk)
   begin
      if (reset)
         address_hold_reg_q <= tbs_pkg::RESET_WORD;
      else if (wr_addr)
         address_hold_reg_q <= addr_d;
   end

   // ********************************************************
   // Registered outputs
   // ********************************************************

   logic [WIDTH-1:0] gen_bits;
   logic [WIDTH-1:0] prop_bits;
   logic gen_all;
   assign gen_bits = op_a & op_b;
   assign prop_bits = op_a | op_b;

   // Group generate across the slice, low bit first.
   always_comb
   begin
      gen_all = 1'b0;
      for (int i = 0; i < WIDTH; i++)
         gen_all = gen_bits[i] | (prop_bits[i] & gen_all);
   end

   // Cascade and shift outputs registered for clean edges; the shift-out
   // bit is only loaded by a shift so it stands until the next shift.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         carry_output <= 1'b0;
         carry_output_oe_n <= 1'b1;
         right_shift_out <= 1'b0;
         right_shift_out_oe_n <= 1'b1;
         look_gen <= 1'b0;
         look_prop <= 1'b0;
      end
      else
      begin
         carry_output <= full_sum[WIDTH];
         carry_output_oe_n <= is_shift;
         if (is_shift)
            right_shift_out <= at[0];
         right_shift_out_oe_n <= !is_shift;
         look_gen <= gen_all;
         look_prop <= &prop_bits;
      end
   end

   // Address bus follows the address register; enabled out of reset.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         addr_out <= tbs_pkg::RESET_WORD;
         addr_out_oe_n <= 1'b1;
         sum_out <= tbs_pkg::RESET_WORD;
         aux_out <= tbs_pkg::RESET_WORD;
      end
      else
      begin
         addr_out <= address_hold_reg_q;
         addr_out_oe_n <= 1'b0;
         sum_out <= sum_register_q;
         aux_out <= aux_q;
      end
   end

   // ********************************************************
   // Checks
   // ********************************************************

   addr_follow_a: assert property (@(posedge clk) disable iff (reset)
      !reset |=> ##1 addr_out == $past(address_hold_reg_q))
      else $error("address bus lags address register");

   grp3_sum_hold_a: assert property (@(posedge clk) disable iff (reset)
      (grp == tbs_pkg::GRP_ADD_ONE && is_scratch)
      |=> $stable(sum_register_q))
      else $error("sum changed on group 3 scratch write");

   grp0_copy_a: assert property (@(posedge clk) disable iff (reset)
      (grp == tbs_pkg::GRP_ADD_BOTH && is_scratch)
      |=> sum_register_q == scratch_q[$past(sel)])
      else $error("sum and scratch differ after group 0");

   shift_en_a: assert property (@(posedge clk) disable iff (reset)
      is_shift |=> !right_shift_out_oe_n && carry_output_oe_n)
      else $error("shift output enables wrong");

   dsm_addr_a: assert property (@(posedge clk) disable iff (reset)
      (grp == tbs_pkg::GRP_ADDR_LOAD && rgrp != tbs_pkg::tbs_grp_three
       && rgrp != tbs_pkg::tbs_grp_none && mask_bus == ones)
      |=> address_hold_reg_q == ones)
      else $error("all-ones mask did not set address");

   carry_en_a: assert property (@(posedge clk) disable iff (reset)
      !is_shift |=> !carry_output_oe_n && right_shift_out_oe_n)
      else $error("carry output enables wrong");

endmodule

// *** verification/tbs_seq_model.sv ***
// Microprogram sequencer model that drives the microfunction and mask fields.
// Assumes the slice samples both fields on the rising edge of clk.
`timescale 1ns/100ps
module tbs_seq_model (
   input wire logic clk,
   output logic [tbs_pkg::FUNC_W-1:0] micro_func,
   output logic [1:0] mask_bus
);
   // ****************
   // Field driving
   // ****************
   // The idle word picks group 4, which this slice leaves alone.
   initial
   begin
      micro_func = {3'h4, 4'h0};
      mask_bus = 2'h0;
   end
   // Presents one microinstruction for exactly one rising edge.
   task automatic issue(input logic [6:0] func, input logic [1:0] k);
   begin
      @(negedge clk);
      micro_func = func;
      mask_bus = k;
      @(negedge clk);
      micro_func = {3'h4, 4'h0};
      mask_bus = 2'h0;
   end
   endtask
endmodule

// *** verification/tbs_slice_bench.sv ***
// Self-checking bench for the two-bit slice datapath, groups 0 to 3.
// Assumes the sequencer model supplies the microfunction and mask fields.
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
   begin \
      checked++; \
      if ((got) !== (ex)) \
      begin \
         errors++; \
         $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
      end \
   end
module tbs_slice_bench;
   logic clk;
   logic reset;
   logic [6:0] micro_func;
   logic [1:0] mask_bus;
   logic [1:0] mem_in;
   logic [1:0] ext_in;
   logic carry_input;
   logic shift_in_high;
   logic right_shift_out;
   logic right_shift_out_oe_n;
   logic carry_output;
   logic carry_output_oe_n;
   logic look_gen;
   logic look_prop;
   logic addr_out_oe_n;
   logic [1:0] addr_out;
   logic [1:0] sum_out;
   logic [1:0] aux_out;
   int errors;
   int checked;
   // ****************
   // Clock and parts
   // ****************
   // The clock toggles every half period of 25 ns.
   always #25 clk = ~clk;
   // The sequencer model drives the control fields.
   tbs_seq_model seq (
      .clk(clk),
      .micro_func(micro_func),
      .mask_bus(mask_bus)
   );
   // The slice under test.
   tbs_slice #(.WIDTH(2)) dut (
      .clk(clk),
      .reset(reset),
      .micro_func(micro_func),
      .mask_bus(mask_bus),
      .mem_in(mem_in),
      .ext_in(ext_in),
      .carry_input(carry_input),
      .shift_in_high(shift_in_high),
      .carry_output(carry_output),
      .carry_output_oe_n(carry_output_oe_n),
      .right_shift_out(right_shift_out),
      .right_shift_out_oe_n(right_shift_out_oe_n),
      .look_gen(look_gen),
      .look_prop(look_prop),
      .addr_out(addr_out),
      .addr_out_oe_n(addr_out_oe_n),
      .sum_out(sum_out),
      .aux_out(aux_out)
   );
   // ****************
   // Tasks
   // ****************
   // Prints the counts and the verdict, then ends the run.
   task automatic results;
   begin
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   end
   endtask
   // Sets the pin buses, lets them pass the two sync flops, runs one op
   // and compares the registers one edge after they were written.
   task automatic step(input logic [6:0] f, input logic [1:0] k, m, i,
                       cl, es, ea, ed);
   begin
      @(negedge clk);
      mem_in = m;
      ext_in = i;
      carry_input = cl[1];
      shift_in_high = cl[0];
      repeat (2) @(negedge clk);
      seq.issue(f, k);
      @(negedge clk);
      `CHK("sum_out", es, sum_out)
      `CHK("aux_out", ea, aux_out)
      `CHK("addr_out", ed, addr_out)
      $display("step with func %0h done", f);
   end
   endtask
   // ****************
   // Watchdog
   // ****************
   // Cuts a hang short well after the expected run of just under two hundred cycles.
   initial
   begin
      #(50 * 1000);
      errors++;
      results();
   end
   // ****************
   // Test sequence
   // ****************
   // Resets the slice, then walks each group with its three targets.
   initial
   begin
      clk = 1'b0;
      reset = 1'b1;
      mem_in = 2'h0;
      ext_in = 2'h0;
      carry_input = 1'b0;
      shift_in_high = 1'b0;
      errors = 0;
      checked = 0;
      repeat (2) @(negedge clk);
      `CHK("addr_out_oe_n", 1'b1, addr_out_oe_n)
      reset = 1'b0;
      repeat (2) @(negedge clk);
      `CHK("addr_out_oe_n", 1'b0, addr_out_oe_n)
      `CHK("sum_out", 2'h0, sum_out)
      step(7'h0b, 2'h0, 2'h2, 2'h0, 2'h0, 2'h2, 2'h0, 2'h0);
      step(7'h3a, 2'h3, 2'h1, 2'h0, 2'h0, 2'h2, 2'h3, 2'h0);
      step(7'h25, 2'h3, 2'h0, 2'h0, 2'h2, 2'h2, 2'h3, 2'h0);
      step(7'h35, 2'h3, 2'h0, 2'h0, 2'h2, 2'h2, 2'h3, 2'h0);
      step(7'h05, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3, 2'h0);
      step(7'h05, 2'h3, 2'h0, 2'h0, 2'h2, 2'h3, 2'h3, 2'h0);
      step(7'h0d, 2'h3, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3, 2'h0);
      step(7'h15, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h3, 2'h3);
      step(7'h15, 2'h1, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3, 2'h1);
      step(7'h15, 2'h3, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3, 2'h3);
      step(7'h1b, 2'h0, 2'h2, 2'h0, 2'h2, 2'h3, 2'h3, 2'h2);
      step(7'h1a, 2'h2, 2'h1, 2'h0, 2'h2, 2'h3, 2'h0, 2'h3);
      step(7'h1e, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h3, 2'h3);
      step(7'h1e, 2'h3, 2'h0, 2'h0, 2'h0, 2'h3, 2'h2, 2'h3);
      step(7'h1f, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3);
      step(7'h2b, 2'h3, 2'h0, 2'h0, 2'h0, 2'h3, 2'h2, 2'h3);
      step(7'h2a, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h3, 2'h3);
      step(7'h2e, 2'h3, 2'h0, 2'h2, 2'h0, 2'h3, 2'h1, 2'h3);
      step(7'h2f, 2'h1, 2'h0, 2'h2, 2'h2, 2'h0, 2'h1, 2'h3);
      step(7'h3e, 2'h3, 2'h0, 2'h2, 2'h0, 2'h0, 2'h3, 2'h3);
      step(7'h3f, 2'h2, 2'h0, 2'h3, 2'h2, 2'h3, 2'h3, 2'h3);
      step(7'h0f, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3, 2'h3);
      `CHK("right_shift_out", 1'b1, right_shift_out)
      step(7'h0f, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3);
      step(7'h0f, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3, 2'h3);
      `CHK("right_shift_out", 1'b0, right_shift_out)
      step(7'h0e, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h3);
      `CHK("right_shift_out", 1'b1, right_shift_out)
      step(7'h0c, 2'h3, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h3);
      step(7'h29, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h3);
      step(7'h09, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h2, 2'h3);
      step(7'h30, 2'h3, 2'h0, 2'h0, 2'h0, 2'h3, 2'h2, 2'h3);
      step(7'h00, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h2, 2'h3);
      step(7'h09, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h2, 2'h3);
      // Cascade outputs stand one cycle, so look right after the op edge.
      seq.issue(7'h0d, 2'h3);
      `CHK("carry_output", 1'b1, carry_output)
      `CHK("carry_output_oe_n", 1'b0, carry_output_oe_n)
      `CHK("right_shift_out_oe_n", 1'b1, right_shift_out_oe_n)
      `CHK("look_gen", 1'b1, look_gen)
      `CHK("look_prop", 1'b1, look_prop)
      seq.issue(7'h0f, 2'h0);
      `CHK("right_shift_out_oe_n", 1'b0, right_shift_out_oe_n)
      `CHK("carry_output_oe_n", 1'b1, carry_output_oe_n)
      `CHK("right_shift_out", 1'b0, right_shift_out)
      @(negedge clk);
      `CHK("sum_out", 2'h1, sum_out)
      $display("cascade output test done");
      results();
   end
endmodule
